// ---- rtl/hrxf_defs.svh ----
/*
 * Register offsets, field positions, reset values and sizes of the
 * HDLC receive FIFO status and readout block.
 * Assumes a 16-bit register port with byte addresses.
 */
// Functional notes
// - full flag live only at 256 bytes
// - empty flag live when no byte stored
// - avail flag when level reaches threshold
// - overflow sets sticky bit 7, byte lost
// - end tagged write sets sticky bit 4
// - start tagged write sets sticky bit 3
// - sticky bit 2 on full rising
// - sticky bit 0 on avail rising
// - irq needs sticky, enable, port enable
// - irq enables reset to zero
// - only upper byte data read pops
// - swap puts first bit in bit 7
// - tags 000 middle, 001 start only
// - end tags 100 to 111 by outcome
// - valid flag zero when empty, resets zero
// - threshold is level field times eight
// - flush empties, discards until next start
// - fcs check on unless disable bit set
`ifndef HRXF_DEFS_SVH
`define HRXF_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define HRXF_OFS_CTRL 8'hB0
`define HRXF_OFS_LIVE 8'hB4
`define HRXF_OFS_STICKY 8'hB6
`define HRXF_OFS_IRQ_EN 8'hB8
`define HRXF_OFS_DATA 8'hBC

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define HRXF_CTRL_FLUSH 0
`define HRXF_CTRL_FCS_OFF 1
`define HRXF_CTRL_SWAP 3
`define HRXF_CTRL_LVL_LSB 8
`define HRXF_CTRL_LVL_MSB 12
`define HRXF_LIVE_FULL 2
`define HRXF_LIVE_EMPTY 1
`define HRXF_LIVE_AVAIL 0
`define HRXF_STK_OVF 7
`define HRXF_STK_PEND 4
`define HRXF_STK_PSTART 3
`define HRXF_STK_FULL 2
`define HRXF_STK_AVAIL 0
`define HRXF_TAG_END_BIT 2

// ----------------------------------------------------------------
// reset values, masks and sizes
// ----------------------------------------------------------------
`define HRXF_CTRL_RESET 16'h0800
`define HRXF_CTRL_MASK 16'h1F0B
`define HRXF_IRQ_EN_RESET 8'h00
`define HRXF_STK_MASK 8'h9D
`define HRXF_DEPTH 9'h100
`define HRXF_TAG_MIDDLE 3'h0
`define HRXF_TAG_START 3'h1

`endif

// ---- rtl/hrxf_pkg.sv ----
/*
 * Types shared by the HDLC receive FIFO readout block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package hrxf_pkg;

    // ------------------------------------------------------------
    // packet end outcome, low two bits of an end tag
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        END_GOOD = 2'h0,
        END_FCS_ERR = 2'h1,
        END_NON_INT = 2'h2,
        END_ABORT = 2'h3
    } hrxf_end_t;

    // ------------------------------------------------------------
    // write-side acceptance state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN = 3'h1,
        ST_FLUSH = 3'h2,
        ST_HUNT = 3'h4
    } hrxf_state_t;

endpackage

// ---- rtl/hrxf_rx_fifo.sv ----
/*
 * HDLC receive FIFO with live and sticky status, interrupt enables
 * and the popping data register, for one port.
 * Assumes the packet processor writes one byte per strobe with its
 * tags, and a host on a plain strobe register port.
 */
`timescale 1ns/1ps
`include "hrxf_defs.svh"

module hrxf_rx_fifo
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [1:0] i_byte_en,
    output logic [15:0] o_rdata,
    input wire logic i_wr_valid,
    input wire logic [7:0] i_wr_byte,
    input wire logic i_wr_sop,
    input wire logic i_wr_eop,
    input wire hrxf_pkg::hrxf_end_t i_wr_end_code,
    input wire logic i_port_irq_en,
    output logic o_irq,
    output logic o_fcs_check_en,
    output logic o_ram_power_down
);

    // ------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------
    logic [10:0] mem_q [0:255];
    logic [7:0] wr_ptr_q;
    logic [7:0] rd_ptr_q;
    logic [8:0] count_q;
    logic [8:0] count_d;
    logic [15:0] ctrl_q;
    logic [7:0] sticky_q;
    logic [7:0] irq_en_q;
    logic full_prev_q;
    logic avail_prev_q;
    logic [15:0] rdata_q;
    hrxf_pkg::hrxf_state_t state_q;

    logic full_live;
    logic empty_live;
    logic avail_live;
    logic [8:0] threshold;
    logic flush;
    logic accept;
    logic push;
    logic pop;
    logic overflow;
    logic [7:0] byte_in;
    logic [2:0] tag_in;
    logic wr_sticky;
    logic [7:0] set_bits;
    logic [10:0] head;

    assign flush = ctrl_q[`HRXF_CTRL_FLUSH];
    assign o_fcs_check_en = ~ctrl_q[`HRXF_CTRL_FCS_OFF];
    assign o_ram_power_down = flush;

    // ------------------------------------------------------------
    // live flags
    // ------------------------------------------------------------
    assign full_live = (count_q == `HRXF_DEPTH);
    assign empty_live = (count_q == 9'h000);

    // level field counts groups of eight bytes
    assign threshold = {1'b0,
        ctrl_q[`HRXF_CTRL_LVL_MSB:`HRXF_CTRL_LVL_LSB], 3'h0};

    // forced low while flushing, even with a zero threshold
    assign avail_live = ~flush && (count_q >= threshold);

    // ------------------------------------------------------------
    // write side
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            state_q <= hrxf_pkg::ST_RUN;
        end
        else
        begin
            unique case (state_q)
                hrxf_pkg::ST_RUN:
                begin
                    if (flush)
                    begin
                        state_q <= hrxf_pkg::ST_FLUSH;
                    end
                end
                hrxf_pkg::ST_FLUSH:
                begin
                    if (!flush)
                    begin
                        state_q <= hrxf_pkg::ST_HUNT;
                    end
                end
                hrxf_pkg::ST_HUNT:
                begin
                    if (flush)
                    begin
                        state_q <= hrxf_pkg::ST_FLUSH;
                    end
                    else if (i_wr_valid && i_wr_sop)
                    begin
                        state_q <= hrxf_pkg::ST_RUN;
                    end
                end
            endcase
        end
    end

    // after a flush, bytes are dropped until a packet start arrives
    always_comb
    begin
        accept = 1'b0;
        if (!flush)
        begin
            if (state_q == hrxf_pkg::ST_RUN)
            begin
                accept = i_wr_valid;
            end
            else if (state_q == hrxf_pkg::ST_HUNT)
            begin
                accept = i_wr_valid && i_wr_sop;
            end
        end
    end

    // a byte may enter a full FIFO only when one leaves at once
    assign push = accept && (!full_live || pop);
    assign overflow = accept && full_live && !pop;

    // bit 0 of the incoming byte is the first bit received
    always_comb
    begin
        byte_in = i_wr_byte;
        if (ctrl_q[`HRXF_CTRL_SWAP])
        begin
            for (int k = 0; k < 8; k++)
            begin
                byte_in[k] = i_wr_byte[7 - k];
            end
        end
    end

    // end wins over start for a one-byte packet
    always_comb
    begin
        if (i_wr_eop)
        begin
            tag_in = {1'b1, i_wr_end_code};
        end
        else if (i_wr_sop)
        begin
            tag_in = `HRXF_TAG_START;
        end
        else
        begin
            tag_in = `HRXF_TAG_MIDDLE;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= {byte_in, tag_in};
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst || flush)
        begin
            wr_ptr_q <= 8'h00;
        end
        else if (push)
        begin
            wr_ptr_q <= wr_ptr_q + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // read side
    // ------------------------------------------------------------
    // only the upper lane pops; an empty FIFO is never popped
    assign pop = i_rd && (i_addr == `HRXF_OFS_DATA) && i_byte_en[1]
        && !empty_live && !flush;

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst || flush)
        begin
            rd_ptr_q <= 8'h00;
        end
        else if (pop)
        begin
            rd_ptr_q <= rd_ptr_q + 8'h01;
        end
    end

    always_comb
    begin
        count_d = count_q;
        if (push && !pop)
        begin
            count_d = count_q + 9'h001;
        end
        else if (pop && !push)
        begin
            count_d = count_q - 9'h001;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst || flush)
        begin
            count_q <= 9'h000;
        end
        else
        begin
            count_q <= count_d;
        end
    end

    assign head = mem_q[rd_ptr_q];

    // ------------------------------------------------------------
    // control and enable registers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            ctrl_q <= `HRXF_CTRL_RESET;
        end
        else if (i_wr && (i_addr == `HRXF_OFS_CTRL))
        begin
            ctrl_q <= i_wdata & `HRXF_CTRL_MASK;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            irq_en_q <= `HRXF_IRQ_EN_RESET;
        end
        else if (i_wr && (i_addr == `HRXF_OFS_IRQ_EN))
        begin
            irq_en_q <= i_wdata[7:0] & `HRXF_STK_MASK;
        end
    end

    // ------------------------------------------------------------
    // sticky flags
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            full_prev_q <= 1'b0;
            avail_prev_q <= 1'b0;
        end
        else
        begin
            full_prev_q <= full_live;
            avail_prev_q <= avail_live;
        end
    end

    always_comb
    begin
        set_bits = 8'h00;
        set_bits[`HRXF_STK_OVF] = overflow;
        set_bits[`HRXF_STK_PEND] = push && i_wr_eop;
        set_bits[`HRXF_STK_PSTART] = push && i_wr_sop;
        set_bits[`HRXF_STK_FULL] = full_live && !full_prev_q;
        set_bits[`HRXF_STK_AVAIL] = avail_live && !avail_prev_q;
    end

    assign wr_sticky = i_wr && (i_addr == `HRXF_OFS_STICKY);

    // a new event in the clearing cycle survives the clear
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            sticky_q <= 8'h00;
        end
        else if (wr_sticky)
        begin
            sticky_q <= (sticky_q & ~i_wdata[7:0]) | set_bits;
        end
        else
        begin
            sticky_q <= sticky_q | set_bits;
        end
    end

    // ------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------
    assign o_irq = i_port_irq_en && |(sticky_q & irq_en_q);

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    // the low byte shows the tag and valid of the byte the next
    // upper-lane read will return, so a byte-wide host reads it first
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            rdata_q <= 16'h0000;
        end
        else if (i_rd)
        begin
            unique case (i_addr)
                `HRXF_OFS_CTRL:
                begin
                    rdata_q <= ctrl_q;
                end
                `HRXF_OFS_LIVE:
                begin
                    rdata_q <= {13'h0000, full_live, empty_live,
                        avail_live};
                end
                `HRXF_OFS_STICKY:
                begin
                    rdata_q <= {8'h00, sticky_q};
                end
                `HRXF_OFS_IRQ_EN:
                begin
                    rdata_q <= {8'h00, irq_en_q};
                end
                `HRXF_OFS_DATA:
                begin
                    if (empty_live || flush)
                    begin
                        rdata_q <= 16'h0000;
                    end
                    else
                    begin
                        rdata_q <= {head[10:3], 4'h0, head[2:0], 1'b1};
                    end
                end
                default:
                begin
                    rdata_q <= 16'h0000;
                end
            endcase
        end
        else
        begin
            rdata_q <= 16'h0000;
        end
    end

    assign o_rdata = rdata_q;

endmodule // hrxf_rx_fifo

// ---- verif/hrxf_pkt_src.sv ----
/*
 * Packet processor stand-in writing tagged bytes into the FIFO.
 * Assumes send and rest are called right after a rising edge.
 */
`timescale 1ns/1ps
module hrxf_pkt_src
(
    input wire logic i_ref_clk,
    output logic o_valid,
    output logic [7:0] o_byte,
    output logic o_sop,
    output logic o_eop,
    output hrxf_pkg::hrxf_end_t o_code
);
    initial
    begin
        o_valid = 1'b0;
        o_byte = 8'h5A;
        o_sop = 1'b0;
        o_eop = 1'b0;
        o_code = hrxf_pkg::END_GOOD;
    end

    task automatic send(input logic [7:0] b, input logic s,
        input logic e, input logic [1:0] c);
        o_valid <= 1'b1;
        o_byte <= b;
        o_sop <= s;
        o_eop <= e;
        o_code <= hrxf_pkg::hrxf_end_t'(c);
        @(posedge i_ref_clk);
    endtask

    // released lines flip so a stale byte never looks valid
    task automatic rest();
        o_valid <= 1'b0;
        o_byte <= ~o_byte;
        o_sop <= ~o_sop;
        o_eop <= ~o_eop;
    endtask
endmodule // hrxf_pkt_src

// ---- verif/hrxf_rx_fifo_sva.sv ----
/*
 * Port checker of the receive FIFO readout block.
 * Assumes it is bound to the block and sees only its ports.
 */
`timescale 1ns/1ps
module hrxf_rx_fifo_sva
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_port_irq_en,
    input wire logic [15:0] o_rdata,
    input wire logic o_irq,
    input wire logic o_fcs_check_en,
    input wire logic o_ram_power_down
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_rd(logic [7:0] a);
        i_rd && i_addr == a;
    endsequence
    sequence s_ctrl_wr;
        i_wr && i_addr == 8'hB0;
    endsequence

    a_rdata_idle:
        assert property (!i_rd |=> o_rdata == 16'h0000)
        else $error("read data outside its slot");
    a_tag_legal:
        assert property (s_rd(8'hBC) |=> o_rdata[7:4] == 4'h0
            && o_rdata[3:2] != 2'b01)
        else $error("reserved tag in data word");
    a_invalid_zero:
        assert property (s_rd(8'hBC) |=> o_rdata[0] || o_rdata == 16'h0000)
        else $error("invalid data word not zero");
    a_live_bits:
        assert property (s_rd(8'hB4) |=> o_rdata[15:3] == 13'h0000
            && !(o_rdata[2] && o_rdata[1]))
        else $error("live status inconsistent");
    a_sticky_resv:
        assert property (s_rd(8'hB6) |=> (o_rdata & 16'hFF62) == 16'h0000)
        else $error("reserved sticky bit set");
    a_irq_gate:
        assert property (!i_port_irq_en |-> !o_irq)
        else $error("interrupt without port enable");
    a_irq_reset:
        assert property ($fell(i_rst) |-> !o_irq)
        else $error("interrupt right after reset");
    a_fcs_follow:
        assert property (s_ctrl_wr |=> o_fcs_check_en == !$past(i_wdata[1]))
        else $error("fcs check enable wrong");
    a_flush_pd:
        assert property (s_ctrl_wr |=> o_ram_power_down == $past(i_wdata[0]))
        else $error("power down wrong");
endmodule // hrxf_rx_fifo_sva

bind hrxf_rx_fifo hrxf_rx_fifo_sva hrxf_rx_fifo_sva_i
(
    .i_ref_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .i_port_irq_en,
    .o_rdata, .o_irq, .o_fcs_check_en, .o_ram_power_down
);

// ---- verif/hrxf_rx_fifo_test.sv ----
/*
 * Self-checking bench of the receive FIFO readout block.
 * Assumes the packet source model and the bound port checker.
 */
`timescale 1ns/1ps
module hrxf_rx_fifo_test;
    logic i_ref_clk, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
    logic i_port_irq_en = 1'b0, rd_seen = 1'b0, sw = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic [1:0] i_byte_en = 2'h3;
    logic i_wr_valid, i_wr_sop, i_wr_eop, o_irq;
    logic o_fcs_check_en, o_ram_power_down;
    logic [7:0] i_wr_byte;
    logic [15:0] o_rdata;
    hrxf_pkg::hrxf_end_t i_wr_end_code;
    int fails = 0;
    int n_compared = 0;
    logic [15:0] exp_q[$], fq[$];

    hrxf_rx_fifo hrxf_rx_fifo_i (.i_ref_clk, .i_rst, .i_addr, .i_wdata,
        .i_wr, .i_rd, .i_byte_en, .o_rdata, .i_wr_valid, .i_wr_byte,
        .i_wr_sop, .i_wr_eop, .i_wr_end_code, .i_port_irq_en, .o_irq,
        .o_fcs_check_en, .o_ram_power_down);
    hrxf_pkt_src hrxf_pkt_src_i (.i_ref_clk, .o_valid(i_wr_valid),
        .o_byte(i_wr_byte), .o_sop(i_wr_sop), .o_eop(i_wr_eop),
        .o_code(i_wr_end_code));

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e)
        begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic finish_test();
        $display("compared %0d mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        i_rd <= 1'b0;
        @(posedge i_ref_clk);
    endtask

    // the expected word is noted as the strobe goes out
    task automatic rd(input logic [7:0] a, input logic [15:0] e,
        input logic [1:0] be = 2'h3);
        i_addr <= a;
        i_byte_en <= be;
        i_rd <= 1'b1;
        i_wr <= 1'b0;
        exp_q.push_back(e);
        @(posedge i_ref_clk);
    endtask

    task automatic idle(input string n = "");
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        hrxf_pkt_src_i.rest();
        repeat (2) @(posedge i_ref_clk);
        if (n != "")
            $display("test %s done", n);
    endtask

    task automatic put(input logic s, input logic e, input logic [1:0] c,
        input logic keep = 1'b1);
        logic [7:0] b;
        logic [7:0] r;
        b = 8'($urandom);
        r = {<<{b}};
        hrxf_pkt_src_i.send(b, s, e, c);
        if (keep)
            fq.push_back({sw ? r : b, 4'h0, e ? {1'b1, c} : {2'b00, s},
                1'b1});
    endtask

    task automatic drain();
        while (fq.size() > 0)
            rd(8'hBC, fq.pop_front());
    endtask

    initial
    begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end

    always @(posedge i_ref_clk)
    begin
        if (rd_seen)
            chk(o_rdata, exp_q.pop_front());
        rd_seen <= i_rd;
    end

    initial
    begin
        repeat (20000) @(posedge i_ref_clk);
        fails++;
        finish_test();
    end

    initial
    begin
        void'($urandom(32'h39FDC932));
        repeat (6) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(posedge i_ref_clk);
        wr(8'hB4, 16'hFFFF);
        rd(8'hB0, 16'h0800);
        rd(8'hB4, 16'h0002);
        rd(8'hB6, 16'h0000);
        rd(8'hB8, 16'h0000);
        rd(8'hBC, 16'h0000);
        rd(8'hB2, 16'h0000);
        idle("reset");
        for (int c = 0; c < 4; c++)
        begin
            sw = c[0];
            wr(8'hB0, {3'h0, 5'h08, 4'h0, sw, 3'h0});
            idle();
            put(1'b1, 1'b0, 2'h0);
            put(1'b0, 1'b0, 2'h0);
            put(1'b0, 1'b1, 2'(c));
            idle();
        end
        rd(8'hB4, 16'h0000);
        rd(8'hB6, 16'h0018);
        wr(8'hB8, 16'hFFFF);
        rd(8'hB8, 16'h009D);
        wr(8'hB6, 16'h0008);
        rd(8'hB6, 16'h0010);
        idle();
        chk({15'h0, o_irq}, 16'h0000);
        i_port_irq_en <= 1'b1;
        idle();
        chk({15'h0, o_irq}, 16'h0001);
        wr(8'hB8, 16'h0008);
        idle();
        chk({15'h0, o_irq}, 16'h0000);
        wr(8'hB6, 16'hFFFF);
        rd(8'hBC, fq[0], 2'h1);
        drain();
        rd(8'hB4, 16'h0002);
        rd(8'hBC, 16'h0000);
        sw = 1'b0;
        wr(8'hB0, 16'h0100);
        idle("packets");
        repeat (7) put(1'b0, 1'b0, 2'h0);
        idle();
        rd(8'hB4, 16'h0000);
        idle();
        put(1'b0, 1'b0, 2'h0);
        idle();
        rd(8'hB4, 16'h0001);
        rd(8'hB6, 16'h0001);
        wr(8'hB6, 16'hFFFF);
        idle("threshold");
        repeat (248) put(1'b0, 1'b0, 2'h0);
        put(1'b0, 1'b0, 2'h0, 1'b0);
        idle();
        rd(8'hB4, 16'h0005);
        rd(8'hB6, 16'h0084);
        wr(8'hB6, 16'hFFFF);
        rd(8'hB6, 16'h0000);
        rd(8'hBC, fq[0], 2'h1);
        rd(8'hB4, 16'h0005);
        rd(8'hBC, fq.pop_front());
        rd(8'hB4, 16'h0001);
        drain();
        wr(8'hB0, 16'h0003);
        idle("full");
        chk({15'h0, o_ram_power_down}, 16'h0001);
        chk({15'h0, o_fcs_check_en}, 16'h0000);
        rd(8'hB4, 16'h0002);
        wr(8'hB0, 16'h0100);
        idle();
        put(1'b0, 1'b0, 2'h0, 1'b0);
        put(1'b1, 1'b1, 2'h2);
        idle();
        rd(8'hB4, 16'h0000);
        drain();
        idle("flush");
        chk({15'h0, o_fcs_check_en}, 16'h0001);
        finish_test();
    end
endmodule // hrxf_rx_fifo_test
